// [design/eppche_engine.sv]
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module eppche_engine
    import eppche_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [5:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output logic      [7:0] rdata_o,
    output logic            host_wait_o,
    output logic            host_done_o,
    output logic      [7:0] host_rdata_o,
    input  wire logic [7:0] port_data_bus_i,
    output logic      [7:0] port_data_bus_o,
    output logic            port_data_bus_oe_o,
    output logic            transfer_dir_line_n_o,
    output logic            data_phase_strobe_n_o,
    output logic            addr_phase_strobe_n_o,
    output logic            periph_reset_n_o,
    output logic            port_dir_bit_o,
    input  wire logic       peripheral_hold_i,
    input  wire logic       periph_irq_in_i,
    input  wire logic       paper_end_i,
    input  wire logic       select_in_i,
    input  wire logic       error_n_i,
    output logic            periph_irq_o
);

    initial begin
        if (WDOG_LIMIT < 2 || WDOG_LIMIT > 65535) begin
            $error("watchdog limit out of range");
        end
    end

    function automatic logic is_epp_port(input logic [3:0] idx);
        is_epp_port = (idx >= IDX_ADDR) && (idx <= IDX_DATA3);
    endfunction : is_epp_port

    logic [3:0]    idx;
    logic          hold_s1;
    logic          hold_s;
    logic          irq_s1;
    logic          irq_s;
    logic [2:0]    pin_s1;
    logic [2:0]    pin_s;
    logic [7:0]    pd_s1;
    logic [7:0]    pd_s;
    eppche_state_t state;
    logic          cyc_addr;
    logic          cyc_wr;
    logic          cyc_ver19;
    logic [15:0]   wd_cnt;
    logic          wd_expire;
    logic [7:0]    out_byte;
    logic [7:0]    rd_byte;
    logic [7:0]    spp_data;
    logic [5:0]    ctrl;
    logic [1:0]    cfg;
    logic          timeout;
    logic          start;
    logic          in_cycle;
    logic          strobing;
    logic          enh_pins;

    assign idx = addr_i[5:2];
    assign start = (we_i || re_i) && is_epp_port(idx) && cfg[CFG_ENABLE]
                   && (state == ST_IDLE);
    assign in_cycle = (state != ST_IDLE);
    assign strobing = (state == ST_STROBE);
    assign enh_pins = in_cycle && (state != ST_ARM);
    assign wd_expire = (wd_cnt == 16'(WDOG_LIMIT - 1));

    // pin synchronisers
    always_ff @(posedge clk_i) begin
        hold_s1 <= peripheral_hold_i;
        hold_s  <= hold_s1;
        irq_s1  <= periph_irq_in_i;
        irq_s   <= irq_s1;
        pin_s1  <= {paper_end_i, select_in_i, error_n_i};
        pin_s   <= pin_s1;
        pd_s1   <= port_data_bus_i;
        pd_s    <= pd_s1;
    end

    // cycle sequencer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= cfg[CFG_VER19] ? ST_ARM : ST_SETUP;
                    end
                end
                ST_ARM: begin
                    if (wd_expire) begin
                        state <= ST_DONE;
                    end else if (!hold_s) begin
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state <= wd_expire ? ST_DONE : ST_STROBE;
                end
                ST_STROBE: begin
                    if (hold_s || wd_expire) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // cycle attributes, latched at start
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cyc_addr  <= 1'b0;
            cyc_wr    <= 1'b0;
            cyc_ver19 <= 1'b0;
            out_byte  <= BYTE_RESET;
        end else if (start) begin
            cyc_addr  <= (idx == IDX_ADDR);
            cyc_wr    <= we_i;
            cyc_ver19 <= cfg[CFG_VER19];
            if (we_i) begin
                out_byte <= wdata_i;
            end
        end
    end

    // watchdog counter
    always_ff @(posedge clk_i) begin
        if (reset_i || !in_cycle || state == ST_DONE) begin
            wd_cnt <= 16'h0000;
        end else begin
            wd_cnt <= wd_cnt + 16'h0001;
        end
    end

    // read capture and host completion
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_byte     <= BYTE_RESET;
            host_done_o <= 1'b0;
        end else begin
            host_done_o <= 1'b0;
            if (strobing && (hold_s || wd_expire)) begin
                host_done_o <= 1'b1;
                if (!cyc_wr) begin
                    rd_byte <= pd_s;
                end
            end
        end
    end

    assign host_wait_o  = in_cycle;
    assign host_rdata_o = rd_byte;

    // timeout flag: hardware set wins over software clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            timeout <= 1'b0;
        end else if (in_cycle && state != ST_DONE && wd_expire) begin
            timeout <= 1'b1;
        end else if (we_i && idx == IDX_STATUS && wdata_i[STS_TIMEOUT]) begin
            timeout <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl     <= CTL_RESET;
            cfg      <= CFG_RESET;
            spp_data <= BYTE_RESET;
        end else if (we_i) begin
            case (idx)
                IDX_DATA:    spp_data <= wdata_i;
                IDX_CONTROL: ctrl     <= wdata_i[5:0];
                IDX_CONFIG:  cfg      <= wdata_i[1:0];
                default:     ;
            endcase
        end
    end

    // register read port
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (re_i) begin
            case (idx)
                IDX_DATA:    rdata_o <= pd_s;
                IDX_STATUS:  rdata_o <= {~hold_s, irq_s, pin_s, 2'b00, timeout};
                IDX_CONTROL: rdata_o <= {2'b00, ctrl};
                IDX_CONFIG:  rdata_o <= {6'h00, cfg};
                default: begin
                    rdata_o <= (is_epp_port(idx) && cfg[CFG_ENABLE]) ? rd_byte : 8'h00;
                end
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // parallel pins: data value
    always_comb begin
        if (enh_pins) begin
            port_data_bus_o = out_byte;
        end else begin
            port_data_bus_o = spp_data;
        end
    end

    // parallel pins: data drive enable; older mode floats when direction bit set
    always_comb begin
        if (enh_pins) begin
            port_data_bus_oe_o = cyc_wr & (cyc_ver19 | ~ctrl[CTL_DIR]);
        end else begin
            port_data_bus_oe_o = ~ctrl[CTL_DIR];
        end
    end

    // parallel pins: direction line
    always_comb begin
        if (enh_pins) begin
            transfer_dir_line_n_o = ~(cyc_wr | ctrl[CTL_STROBE]);
        end else begin
            transfer_dir_line_n_o = ~ctrl[CTL_STROBE];
        end
    end

    // parallel pins: data strobe
    always_comb begin
        if (enh_pins) begin
            data_phase_strobe_n_o = ~(strobing & ~cyc_addr);
        end else begin
            data_phase_strobe_n_o = ~ctrl[CTL_AUTOFD];
        end
    end

    // parallel pins: address strobe
    always_comb begin
        if (enh_pins) begin
            addr_phase_strobe_n_o = ~(strobing & cyc_addr);
        end else begin
            addr_phase_strobe_n_o = ~ctrl[CTL_SELECT];
        end
    end

    // parallel pins: direction bit
    always_comb begin
        if (enh_pins) begin
            port_dir_bit_o = cyc_ver19 ? ~cyc_wr : ctrl[CTL_DIR];
        end else begin
            port_dir_bit_o = ctrl[CTL_DIR];
        end
    end

    assign periph_reset_n_o = ctrl[CTL_INIT];
    assign periph_irq_o     = irq_s & ctrl[CTL_IRQE];

endmodule : eppche_engine

// [design/eppche_pkg.sv]
package eppche_pkg;

    // register indexes; byte address is four times the index
    localparam logic [3:0] IDX_DATA    = 4'h0;
    localparam logic [3:0] IDX_STATUS  = 4'h1;
    localparam logic [3:0] IDX_CONTROL = 4'h2;
    localparam logic [3:0] IDX_ADDR    = 4'h3;
    localparam logic [3:0] IDX_DATA0   = 4'h4;
    localparam logic [3:0] IDX_DATA3   = 4'h7;
    localparam logic [3:0] IDX_CONFIG  = 4'h8;

    // control register fields
    localparam int CTL_STROBE  = 0;
    localparam int CTL_AUTOFD  = 1;
    localparam int CTL_INIT    = 2;
    localparam int CTL_SELECT  = 3;
    localparam int CTL_IRQE    = 4;
    localparam int CTL_DIR     = 5;
    localparam logic [5:0] CTL_RESET = 6'h00;

    // status register fields
    localparam int STS_TIMEOUT = 0;
    localparam int STS_ERROR   = 3;
    localparam int STS_SELECT  = 4;
    localparam int STS_PAPER   = 5;
    localparam int STS_IRQ     = 6;
    localparam int STS_NBUSY   = 7;

    // config register fields
    localparam int CFG_ENABLE  = 0;
    localparam int CFG_VER19   = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;

    localparam logic [7:0] BYTE_RESET = 8'h00;

    // cycle watchdog
    localparam int WDOG_NS     = 10000;
    localparam int CLK_NS      = 10;
    localparam int WDOG_CYCLES = WDOG_NS / CLK_NS + 1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ARM    = 3'b001,
        ST_SETUP  = 3'b011,
        ST_STROBE = 3'b010,
        ST_DONE   = 3'b110
    } eppche_state_t;

endpackage : eppche_pkg

// [tb/eppche_engine_props.sv]
`timescale 1ns/10ps
module eppche_engine_props #(
    parameter int WDOG_LIMIT = 20
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic host_wait_o,
    input wire logic host_done_o,
    input wire logic port_data_bus_oe_o,
    input wire logic port_dir_bit_o,
    input wire logic data_phase_strobe_n_o,
    input wire logic addr_phase_strobe_n_o,
    input wire logic periph_irq_in_i,
    input wire logic periph_irq_o
);
    localparam int WD_MAX = WDOG_LIMIT + 6;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_strb;
        !data_phase_strobe_n_o || !addr_phase_strobe_n_o;
    endsequence
    a_one_strobe: assert property (data_phase_strobe_n_o || addr_phase_strobe_n_o)
        else $error("both strobes low");
    a_strobe_busy: assert property (s_strb |-> host_wait_o)
        else $error("strobe outside cycle");
    a_read_floats: assert property (s_strb ##0 port_dir_bit_o |-> !port_data_bus_oe_o)
        else $error("bus driven in read");
    a_release_done: assert property ($rose(data_phase_strobe_n_o) || $rose(addr_phase_strobe_n_o)
        |-> host_done_o)
        else $error("strobe dropped early");
    a_done_ends: assert property (host_done_o |=> !host_done_o && !host_wait_o)
        else $error("cycle not ended");
    a_wait_holds: assert property (host_wait_o && !host_done_o |=> host_wait_o || host_done_o)
        else $error("wait dropped");
    a_wdog_bound: assert property ($rose(host_wait_o) |-> ##[1:WD_MAX] host_done_o)
        else $error("cycle too long");
    a_idle_quiet: assert property (!host_wait_o |-> data_phase_strobe_n_o && addr_phase_strobe_n_o)
        else $error("strobe while idle");
    a_irq_follow: assert property ((!periph_irq_in_i)[*3] |=> !periph_irq_o)
        else $error("irq not followed");
endmodule : eppche_engine_props
bind eppche_engine eppche_engine_props #(.WDOG_LIMIT(WDOG_LIMIT)) u_props (.clk_i, .reset_i,
    .host_wait_o, .host_done_o, .port_data_bus_oe_o, .port_dir_bit_o, .data_phase_strobe_n_o,
    .addr_phase_strobe_n_o, .periph_irq_in_i, .periph_irq_o);

// [tb/eppche_engine_tb.sv]
`timescale 1ns/10ps
module eppche_engine_tb;
    import eppche_pkg::*;
    localparam int WD = 40;
    logic clk_i = 1'b0, reset_i = 1'b1, we_i = 1'b0, re_i = 1'b0, irq = 1'b0, idle_hold = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00, dly = 8'h02, rbyte = 8'h00;
    logic [7:0] rdata_o, host_rdata_o, dbus_o, mbus, pins, wbyte, v, d;
    logic wait_o, done_o, oe, dir_n, ds_n, as_n, prst_n, port_dir_bit, hold, irq_o;
    logic [31:0] seed = 32'h00002f54;
    int bad_count = 0, check_count = 0, cyc = 0, nd = 0, na = 0, nw = 0, ndone = 0, n, k;
    assign pins = oe ? dbus_o : mbus;
    eppche_engine #(.WDOG_LIMIT(WD)) u_dut (
        .clk_i, .reset_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .host_rdata_o,
        .host_wait_o(wait_o), .host_done_o(done_o), .port_data_bus_i(pins),
        .port_data_bus_o(dbus_o), .port_data_bus_oe_o(oe), .transfer_dir_line_n_o(dir_n),
        .data_phase_strobe_n_o(ds_n), .addr_phase_strobe_n_o(as_n), .periph_reset_n_o(prst_n),
        .port_dir_bit_o(port_dir_bit), .peripheral_hold_i(hold), .periph_irq_in_i(irq),
        .paper_end_i(1'b0), .select_in_i(1'b0), .error_n_i(1'b1), .periph_irq_o(irq_o));
    eppche_periph_model u_periph (
        .clk_i, .strobe_n_i(ds_n & as_n), .oe_i(oe), .pins_i(pins), .idle_hold_i(idle_hold),
        .delay_i(dly), .rd_byte_i(rbyte), .hold_o(hold), .bus_o(mbus), .wr_byte_o(wbyte));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (done_o) ndone <= ndone + 1;
        if (!ds_n) nd <= nd + 1;
        if (!as_n) na <= na + 1;
        if (!dir_n && !(ds_n && as_n)) nw <= nw + 1;
        if (cyc == 20000) begin
            bad_count++;
            $display("mismatch %0t run too long", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic wr(input logic [5:0] a, input logic [7:0] x);
        addr_i <= a;
        wdata_i <= x;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] x);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 x = rdata_o;
        @(posedge clk_i);
    endtask : rd
    task automatic epp(input logic [5:0] a, input logic w, input logic [7:0] x);
        int n0, d0, a0, w0;
        n0 = ndone;
        d0 = nd;
        a0 = na;
        w0 = nw;
        n = 0;
        addr_i <= a;
        wdata_i <= x;
        we_i <= w;
        re_i <= !w;
        @(posedge clk_i);
        we_i <= 1'b0;
        re_i <= 1'b0;
        while (ndone == n0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h0, na != a0}, {7'h0, a[5:2] == IDX_ADDR});
        chk({7'h0, nd != d0}, {7'h0, a[5:2] != IDX_ADDR});
        chk({7'h0, nw != w0}, {7'h0, w});
        v = host_rdata_o;
    endtask : epp
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        chk({7'h0, prst_n}, 8'h00);
        rd(6'h08, v);
        chk(v, 8'h00);
        wr(6'h10, 8'h5a);
        repeat (3) @(posedge clk_i);
        chk(8'(ndone), 8'h00);
        wr(6'h08, 8'h14);
        irq <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({6'h0, prst_n, irq_o}, 8'h03);
        irq <= 1'b0;
        wr(6'h20, 8'h03);
        for (int i = 0; i < 10; i++) begin
            rbyte <= rnd();
            dly <= 8'h01 + (rnd() & 8'h07);
            d = rnd();
            epp(6'h0c + 6'(i % 5 * 4), i[0], d);
            chk(i[0] ? wbyte : v, i[0] ? d : rbyte);
        end
        idle_hold <= 1'b1;
        repeat (4) @(posedge clk_i);
        k = nd;
        fork
            epp(6'h10, 1'b0, 8'h00);
            begin
                repeat (6) @(posedge clk_i);
                chk(8'(nd - k), 8'h00);
                idle_hold <= 1'b0;
            end
        join
        chk(v, rbyte);
        wr(6'h20, 8'h01);
        wr(6'h08, 8'h24);
        rbyte <= rnd();
        epp(6'h14, 1'b0, 8'h00);
        chk({7'h0, port_dir_bit}, 8'h01);
        chk(v, rbyte);
        wr(6'h08, 8'h04);
        d = rnd();
        epp(6'h0c, 1'b1, d);
        chk(wbyte, d);
        dly <= 8'hff;
        epp(6'h10, 1'b1, 8'h00);
        chk({7'h0, n >= WD && n <= WD + 6}, 8'h01);
        rd(6'h04, v);
        chk(v & 8'h01, 8'h01);
        wr(6'h04, 8'h01);
        rd(6'h04, v);
        chk(v & 8'h01, 8'h00);
        test_done();
    end
endmodule : eppche_engine_tb

// [tb/eppche_periph_model.sv]
`timescale 1ns/10ps
module eppche_periph_model (
    input  wire logic       clk_i,
    input  wire logic       strobe_n_i,
    input  wire logic       oe_i,
    input  wire logic [7:0] pins_i,
    input  wire logic       idle_hold_i,
    input  wire logic [7:0] delay_i,
    input  wire logic [7:0] rd_byte_i,
    output logic            hold_o,
    output logic      [7:0] bus_o,
    output logic      [7:0] wr_byte_o
);
    logic [7:0] cnt;
    initial begin
        hold_o = 1'b0;
        bus_o = 8'h00;
        wr_byte_o = 8'h00;
        cnt = 8'h00;
    end
    // delay of 8'hff never answers
    always @(posedge clk_i) begin
        if (strobe_n_i) begin
            cnt <= 8'h00;
            hold_o <= idle_hold_i;
            bus_o <= ~bus_o;
        end else begin
            if (cnt != delay_i)
                cnt <= cnt + 8'h01;
            hold_o <= cnt == delay_i && delay_i != 8'hff;
            bus_o <= rd_byte_i;
            if (oe_i)
                wr_byte_o <= pins_i;
        end
    end
endmodule : eppche_periph_model
